// >>> rtl/isc_pkg.sv
// constants for the identification and system configuration register bank
// assumes a 16-bit special-function register port on the core clock
package isc_pkg;
    // special-function register word addresses
    localparam logic [15:0] ADDR_MANUFACTURER = 16'hF07E;
    localparam logic [15:0] ADDR_CHIP_REV = 16'hF07C;
    localparam logic [15:0] ADDR_MEMORY = 16'hF07A;
    localparam logic [15:0] ADDR_PROG_VOLT = 16'hF078;
    localparam logic [15:0] ADDR_SYS_CONFIG = 16'hFF12;

    // fixed identification contents
    localparam logic [15:0] MEMORY_DESC_VALUE = 16'h3080;
    localparam logic [15:0] PROG_VOLT_VALUE = 16'h0040;
    localparam logic [3:0] FLASH_KIND = 4'h3;
    localparam logic [4:0] MAKER_CODE_FIELD_LOW_BITS = 5'h01;

    // system configuration field positions
    localparam int STACK_HI = 15;
    localparam int STACK_LO = 13;
    localparam int BIT_SEGMENT_MAP = 12;
    localparam int BIT_SEG_DISABLE = 11;
    localparam int BIT_MEM_ENABLE = 10;
    localparam int BIT_HIGH_BYTE_DIS = 9;
    localparam int BIT_CLOCK_OUT = 8;
    localparam int BIT_WRITE_CFG = 7;
    localparam int BIT_CS_TIMING = 6;
    localparam int BIT_POWER_DOWN = 5;
    localparam int BIT_OSC_MON_DIS = 4;
    localparam int BIT_BIDIR_RESET = 3;
    localparam int BIT_EXT_PERIPH = 2;
    localparam int BIT_VISIBLE = 1;
    localparam int BIT_SHARE = 0;

    // configuration value before strap bits are merged in
    localparam logic [15:0] SYS_CONFIG_RESET = 16'h0000;

    // timing of the bidirectional reset drive, in half clock units
    localparam int RESET_DRIVE_TCL = 1024;
    localparam int TCL_PER_CYCLE = 2;
    localparam int RESET_DRIVE_CYCLES = RESET_DRIVE_TCL / TCL_PER_CYCLE;
endpackage

// >>> rtl/isc_regs.sv
// identification words and system configuration register bank
// assumes single-cycle special-function register port; straps are asynchronous pins
//
// Function
// - four read-only identification words live in the extended register space
// - identification words ignore writes and always read their fixed value
// - chip word holds device code above a four-bit silicon revision
// - memory word holds kind 3h for flash above a size field
// - config register: stack size bits 15..13, then control bits down to 0
// - memory enable comes from the access pin, high-byte disable and write config from straps at reset
// - after end-of-init, config writes are ignored until next reset
// - extension peripherals blocked while the peripheral enable is 0
// - bidirectional reset drives reset pin low 1024 half clocks
// - chip selects change one clock cycle (two half clocks) after latch edge, or on it
// - clock output pin toggles at half the system clock rate when enabled, else general I/O
`timescale 1ns/1ps
module isc_regs
    import isc_pkg::*;
#(
    parameter logic [11:0] DEVICE_CODE = 12'h2A5, // arbitrary value
    parameter logic [3:0] SILICON_REV = 4'h1, // arbitrary value
    parameter logic [10:0] MAKER_CODE = 11'h055, // arbitrary value
    parameter int RESET_DRIVE_LEN = RESET_DRIVE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic softReset,
    input wire logic [15:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic regHit,
    input wire logic endOfInit,
    input wire logic [15:0] port0Strap,
    input wire logic externalAccessPin,
    output logic resetPinOut,
    output logic resetPinOe,
    output logic clockOutPin,
    output logic clockOutSelect,
    input wire logic latchEdge,
    output logic chipSelectUpdate,
    output logic [15:0] sysConfig,
    output logic extPeriphAccessOk,
    input wire logic extPeriphRequest,
    output logic extPeriphGrant
);

    ////////////////////////////////////////////////////////////////////////
    // counter sized from the drive length, so a longer drive cannot wrap
    localparam int DRIVE_WIDTH = (RESET_DRIVE_LEN > 1) ? $clog2(RESET_DRIVE_LEN) : 1;

    logic [15:0] strapSync;
    logic eaSync;
    logic strapLoad;
    logic strapped_q;
    logic configWriteHit;
    logic [15:0] config_d;
    logic [15:0] config_q;
    logic locked_q;
    logic [15:0] readWord;
    logic addrHit;
    logic driveStart;
    logic [DRIVE_WIDTH-1:0] drive_q;
    logic driving_q;
    logic csDelay_q;
    logic clkDiv_q;
    logic [15:0] manufWord;
    logic [15:0] chipWord;

    // straps and the access pin come from outside the clock domain
    isc_sync #(
        .WIDTH(16)
    ) strapSyncer (
        .sys_clk(sys_clk),
        .asyncIn(port0Strap),
        .syncOut(strapSync)
    );

    isc_sync #(
        .WIDTH(1)
    ) eaSyncer (
        .sys_clk(sys_clk),
        .asyncIn(externalAccessPin),
        .syncOut(eaSync)
    );

    ////////////////////////////////////////////////////////////////////////
    assign manufWord = {MAKER_CODE, MAKER_CODE_FIELD_LOW_BITS};
    assign chipWord = {DEVICE_CODE, SILICON_REV};

    ////////////////////////////////////////////////////////////////////////
    // straps are caught on the first clean edge after release, not under reset
    assign strapLoad = !strapped_q;
    assign configWriteHit = regWrite && (regAddr == ADDR_SYS_CONFIG);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            strapped_q <= 1'b0;
        end else begin
            strapped_q <= 1'b1;
        end
    end

    // a write in the end-of-init cycle still lands; the lock starts after it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            locked_q <= 1'b0;
        end else if (endOfInit) begin
            locked_q <= 1'b1;
        end
    end

    always_comb begin
        config_d = config_q;
        if (strapLoad) begin
            config_d[BIT_MEM_ENABLE] = eaSync;
            config_d[BIT_HIGH_BYTE_DIS] = strapSync[BIT_HIGH_BYTE_DIS];
            config_d[BIT_WRITE_CFG] = ~strapSync[BIT_WRITE_CFG];
        end else if (configWriteHit && !locked_q) begin
            config_d = regWdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            config_q <= SYS_CONFIG_RESET;
        end else begin
            config_q <= config_d;
        end
    end

    assign sysConfig = config_q;

    ////////////////////////////////////////////////////////////////////////
    // identification words have no storage, so writes cannot alter them
    always_comb begin
        addrHit = 1'b1;
        case (regAddr)
            ADDR_MANUFACTURER: readWord = manufWord;
            ADDR_CHIP_REV: readWord = chipWord;
            ADDR_MEMORY: readWord = MEMORY_DESC_VALUE;
            ADDR_PROG_VOLT: readWord = PROG_VOLT_VALUE;
            ADDR_SYS_CONFIG: readWord = config_q;
            default: begin
                readWord = 16'h0000;
                addrHit = 1'b0;
            end
        endcase
    end

    // combinational read, so no word of the bank adds a wait state
    assign regRdata = regRead ? readWord : 16'h0000;
    assign regHit = addrHit;

    ////////////////////////////////////////////////////////////////////////
    // only a software or watchdog reset starts the drive; a hard reset is the pin itself
    assign driveStart = softReset && config_q[BIT_BIDIR_RESET];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            drive_q <= '0;
            driving_q <= 1'b0;
        end else if (driveStart) begin
            drive_q <= DRIVE_WIDTH'(RESET_DRIVE_LEN - 1);
            driving_q <= 1'b1;
        end else if (driving_q) begin
            if (drive_q == '0) begin
                driving_q <= 1'b0;
            end else begin
                drive_q <= drive_q - DRIVE_WIDTH'(1);
            end
        end
    end

    assign resetPinOut = 1'b0;
    assign resetPinOe = driving_q && config_q[BIT_BIDIR_RESET];

    ////////////////////////////////////////////////////////////////////////
    // one cycle equals two half clock units, so the latched case lags a cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            csDelay_q <= 1'b0;
        end else begin
            csDelay_q <= latchEdge;
        end
    end

    // pin toggles at half the core rate; a true clock cannot leave a flop
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clkDiv_q <= 1'b0;
        end else begin
            clkDiv_q <= ~clkDiv_q;
        end
    end

    assign chipSelectUpdate = config_q[BIT_CS_TIMING] ? latchEdge : csDelay_q;
    assign clockOutSelect = config_q[BIT_CLOCK_OUT];
    assign clockOutPin = config_q[BIT_CLOCK_OUT] & clkDiv_q;
    assign extPeriphAccessOk = config_q[BIT_EXT_PERIPH];
    assign extPeriphGrant = extPeriphRequest & config_q[BIT_EXT_PERIPH];

endmodule

////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser; only the second flop is read outside
module isc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge sys_clk) begin
        meta_q <= asyncIn;
        sync_q <= meta_q;
    end

    assign syncOut = sync_q;

endmodule

// >>> verification/isc_regs_monitor.sv
// assertions on the id and configuration bank ports
// assumes bound to isc_regs with an 8-cycle reset drive
`timescale 1ns/1ps
module isc_regs_monitor
    import isc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic softReset,
    input wire logic [15:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic endOfInit,
    input wire logic latchEdge,
    input wire logic chipSelectUpdate,
    input wire logic [15:0] sysConfig,
    input wire logic extPeriphRequest,
    input wire logic extPeriphGrant,
    input wire logic resetPinOe,
    input wire logic regHit,
    input wire logic clockOutPin,
    input wire logic resetPinOut
);
    logic lockQ;
    always_ff @(posedge sys_clk) lockQ <= !reset && (lockQ || endOfInit);
    logic mapped;
    assign mapped = regAddr inside {ADDR_MANUFACTURER, ADDR_CHIP_REV, ADDR_MEMORY, ADDR_PROG_VOLT,
        ADDR_SYS_CONFIG};
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    ////////
    AST_MEM: assert property (regRead && regAddr == ADDR_MEMORY |-> regRdata == 16'h3080)
        else $error("memory word wrong");
    AST_PROG: assert property (regRead && regAddr == ADDR_PROG_VOLT |-> regRdata == 16'h0040)
        else $error("voltage word wrong");
    AST_GAP: assert property (regRead && !mapped |-> regRdata == 16'h0000 && !regHit)
        else $error("unmapped read not zero");
    AST_WR: assert property (regWrite && regAddr == ADDR_SYS_CONFIG && !lockQ && !softReset
        && !$past(reset) |=> sysConfig == $past(regWdata))
        else $error("config write lost");
    AST_LOCK: assert property (lockQ && !softReset |=> $stable(sysConfig))
        else $error("config changed after lock");
    AST_CS: assert property (latchEdge && !sysConfig[6] |-> !chipSelectUpdate ##1 chipSelectUpdate)
        else $error("chip select timing wrong");
    AST_GNT: assert property (extPeriphGrant == (extPeriphRequest && sysConfig[2]))
        else $error("grant wrong");
    AST_DRV: assert property (softReset && sysConfig[3] && !resetPinOe |=> resetPinOe[*8] ##1 !resetPinOe)
        else $error("reset drive length wrong");
    AST_HIT: assert property (regHit == mapped)
        else $error("address hit wrong");
    AST_CSU: assert property (latchEdge && sysConfig[BIT_CS_TIMING] |-> chipSelectUpdate)
        else $error("unlatched chip select late");
    AST_CLKOFF: assert property (!sysConfig[BIT_CLOCK_OUT] |-> !clockOutPin)
        else $error("clock pin active while disabled");
    AST_CLKRUN: assert property (sysConfig[8] && $past(sysConfig[8])
        |-> clockOutPin != $past(clockOutPin))
        else $error("clock pin not toggling");
    AST_RSTOFF: assert property (!sysConfig[BIT_BIDIR_RESET] |-> !resetPinOe)
        else $error("reset pin driven while disabled");
    AST_RSTLOW: assert property (resetPinOe |-> !resetPinOut)
        else $error("reset pin driven high");
endmodule
////////
bind isc_regs isc_regs_monitor mon (.sys_clk, .reset, .softReset, .regAddr, .regWrite, .regRead,
    .regWdata, .regRdata, .endOfInit, .latchEdge, .chipSelectUpdate, .sysConfig,
    .extPeriphRequest, .extPeriphGrant, .resetPinOe, .regHit, .clockOutPin, .resetPinOut);

// >>> verification/testbench.sv
// self-checking bench for the id and configuration bank
// assumes isc_regs with the reset drive cut to 8 cycles
`timescale 1ns/1ps
module testbench;
    import isc_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, softReset = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic endOfInit = 1'b0, externalAccessPin = 1'b1, latchEdge = 1'b0, extPeriphRequest = 1'b0;
    logic [15:0] regAddr = 16'h0000, regWdata = 16'h0000, port0Strap, lfsr = 16'h2B63, cfg;
    logic [15:0] regRdata, sysConfig, qe[$], qm[$];
    logic [15:0] strapCfg;
    logic resetPinOe, extPeriphGrant, clockOutSelect, extPeriphAccessOk;
    int err_total = 0, n_tests = 0, cnt;
    // identity values here are arbitrary
    isc_regs #(.DEVICE_CODE(12'h123), .SILICON_REV(4'h7), .MAKER_CODE(11'h055),
        .RESET_DRIVE_LEN(8)) dut (.sys_clk, .reset, .softReset, .regAddr, .regWrite,
        .regRead, .regWdata, .regRdata, .regHit(), .endOfInit, .port0Strap, .externalAccessPin,
        .resetPinOut(), .resetPinOe, .clockOutPin(), .clockOutSelect, .latchEdge,
        .chipSelectUpdate(), .sysConfig, .extPeriphAccessOk, .extPeriphRequest, .extPeriphGrant);
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            err_total++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    // expected read data is queued here, compared by the watcher below
    task rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        qe.push_back(e & m);
        qm.push_back(m);
        @(posedge sys_clk);
        regRead <= 1'b0;
    endtask
    task report_and_stop;
        if (err_total == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////
    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin
        #20000;
        err_total++;
        report_and_stop;
    end
    always @(negedge sys_clk) if (regRead === 1'b1 && qe.size() > 0) begin
        chk("regRdata", qe[0], regRdata & qm[0]);
        void'(qe.pop_front());
        void'(qm.pop_front());
    end
    initial begin
        port0Strap = lf(lfsr);
        strapCfg = {5'h00, externalAccessPin, port0Strap[9], 1'b0, ~port0Strap[7], 7'h00};
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(ADDR_SYS_CONFIG, strapCfg, 16'hFFFF);
        rd(ADDR_MEMORY, MEMORY_DESC_VALUE, 16'hFFFF);
        rd(ADDR_CHIP_REV, 16'h1237, 16'hFFFF);
        rd(ADDR_MANUFACTURER, 16'h0AA1, 16'hFFFF);
        wr(ADDR_PROG_VOLT, 16'hFFBF);
        rd(ADDR_PROG_VOLT, PROG_VOLT_VALUE, 16'hFFFF);
        rd(16'h1234, 16'h0000, 16'hFFFF);
        // random values reach every config bit, both chip select modes included
        repeat (6) begin
            lfsr = lf(lfsr);
            cfg = lfsr;
            wr(ADDR_SYS_CONFIG, cfg);
            rd(ADDR_SYS_CONFIG, cfg, 16'hFFFF);
            extPeriphRequest <= lfsr[1];
            latchEdge <= 1'b1;
            @(posedge sys_clk);
            latchEdge <= 1'b0;
            @(negedge sys_clk);
            chk("grant", 16'(cfg[2] & lfsr[1]), 16'(extPeriphGrant));
            chk("clkSel", 16'(cfg[8]), 16'(clockOutSelect));
            chk("access", 16'(cfg[2]), 16'(extPeriphAccessOk));
        end
        wr(ADDR_SYS_CONFIG, 16'h014C);
        endOfInit <= 1'b1;
        @(posedge sys_clk);
        endOfInit <= 1'b0;
        wr(ADDR_SYS_CONFIG, 16'h0000);
        rd(ADDR_SYS_CONFIG, 16'h014C, 16'hFFFF);
        softReset <= 1'b1;
        @(posedge sys_clk);
        softReset <= 1'b0;
        cnt = 0;
        repeat (20) @(negedge sys_clk) cnt += (resetPinOe === 1'b1);
        chk("drive", 16'(cnt), 16'h0008);
        // a second reset must reload the straps and lift the lock
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(ADDR_SYS_CONFIG, strapCfg, 16'hFFFF);
        wr(ADDR_SYS_CONFIG, 16'h0A5A);
        rd(ADDR_SYS_CONFIG, 16'h0A5A, 16'hFFFF);
        report_and_stop;
    end
endmodule
